// ### pkg/pcau_map.vh
/*
 * constants for the counter, compare and arithmetic unit: opcodes, widths,
 * counter bank size and condition code bit positions.
 * assumes it is included by bare name from the core file, the checker and the bench.
 */
`ifndef PCAU_MAP_VH
`define PCAU_MAP_VH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define PCAU_OP_NOP    5'h00
`define PCAU_OP_SET    5'h01
`define PCAU_OP_RST    5'h02
`define PCAU_OP_UP     5'h03
`define PCAU_OP_DOWN   5'h04
`define PCAU_OP_SCAN   5'h05
`define PCAU_OP_LDBIN  5'h06
`define PCAU_OP_LDBCD  5'h07
`define PCAU_OP_EQ     5'h08
`define PCAU_OP_NE     5'h09
`define PCAU_OP_GT     5'h0a
`define PCAU_OP_GE     5'h0b
`define PCAU_OP_LT     5'h0c
`define PCAU_OP_LE     5'h0d
`define PCAU_OP_ADD    5'h0e
`define PCAU_OP_SUB    5'h0f
`define PCAU_OP_LDWORD 5'h10

// ----------------------------------------------------------------
// sizes and limits
// ----------------------------------------------------------------
`define PCAU_CNT_NUM   16
`define PCAU_CNT_AW    4
`define PCAU_CNT_MAX   10'h3e7
`define PCAU_WORD_W    16

// ----------------------------------------------------------------
// condition code bits: cc1, cc0, overflow
// ----------------------------------------------------------------
`define PCAU_CC_CC1    2
`define PCAU_CC_CC0    1
`define PCAU_CC_OV     0
`define PCAU_CC_RST    3'h0

`endif

// ### core/pcau_core.v
/*
 * counter bank, accumulator compare and fixed-point add/subtract unit.
 * assumes the sequencer presents one operation per op_valid_i pulse, with
 * operands synchronous to core_clk_i; every result is visible one cycle later.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pcau_map.vh"

// Contract
// - each counter stays within 0 to 999.
// - set loads the counter only on a rising logic result bit.
// - set takes its count from the primary operand register.
// - reset forces zero whenever the logic result bit is one.
// - count up adds one on a rising logic result bit.
// - count down subtracts one on a rising logic result bit.
// - with the logic result bit low, up and down change nothing.
// - scan yields one for a nonzero count, zero otherwise.
// - load puts the present count into the primary operand register.
// - bcd load delivers the count as three bcd digits.
// - comparisons leave both operand registers untouched.
// - equality compares raw bit patterns.
// - inequality compares raw bit patterns.
// - greater tests compare secondary against primary, signed.
// - less tests compare secondary against primary, signed.
// - comparisons run whatever the incoming logic result bit.
// - comparison verdict is written to the logic result bit.
// - comparisons update the condition code flags.
// - arithmetic writes its result into the primary operand register.
// - addition sums both operand registers.
// - subtraction computes secondary minus primary.
// - arithmetic operands are 16-bit signed fixed point.
// - arithmetic leaves the secondary operand register unchanged.
// - arithmetic keeps the logic result bit, sets condition codes.
// - a load first shifts primary into secondary.
module pcau_core
(
    input  wire        core_clk_i,
    input  wire        nrst_i,
    input  wire        op_valid_i,
    input  wire [4:0]  op_code_i,
    input  wire [3:0]  cnt_sel_i,
    input  wire        logic_result_bit_i,
    input  wire [15:0] load_word_i,
    input  wire [15:0] primary_operand_register_i,
    input  wire [15:0] secondary_operand_register_i,
    input  wire        accu_wr_i,
    output reg         logic_result_bit_o,
    output reg  [15:0] primary_operand_register_o,
    output reg  [15:0] secondary_operand_register_o,
    output reg  [2:0]  cond_code_o,
    output reg         done_o
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    reg  [9:0]  count_r [0:`PCAU_CNT_NUM-1];
    reg         edge_mem_r [0:`PCAU_CNT_NUM-1];

    wire [9:0]  cur_cnt   = count_r[cnt_sel_i];
    wire        prev_lrb  = edge_mem_r[cnt_sel_i];
    wire        rise      = logic_result_bit_i & ~prev_lrb;
    wire [15:0] acc1      = primary_operand_register_o;
    wire [15:0] acc2      = secondary_operand_register_o;

    // ----------------------------------------------------------------
    // bcd conversion
    // ----------------------------------------------------------------
    // bcd word to binary, digits above 9 clamp
    wire [3:0]  bcd_h     = (acc1[11:8] > 4'h9) ? 4'h9 : acc1[11:8];
    wire [3:0]  bcd_t     = (acc1[7:4]  > 4'h9) ? 4'h9 : acc1[7:4];
    wire [3:0]  bcd_u     = (acc1[3:0]  > 4'h9) ? 4'h9 : acc1[3:0];
    wire [9:0]  set_val   = {6'h00, bcd_h} * 10'h064 + {6'h00, bcd_t} * 10'h00a
                            + {6'h00, bcd_u};

    // binary count to three bcd digits
    // quotients stay ten bits wide and are cut to a digit on purpose below
    wire [9:0]  quo_h     = cur_cnt / 10'h064;
    wire [9:0]  rem_h     = cur_cnt % 10'h064;
    wire [9:0]  quo_t     = rem_h / 10'h00a;
    wire [9:0]  rem_t     = rem_h % 10'h00a;
    wire [3:0]  dig_h     = quo_h[3:0];
    wire [3:0]  dig_t     = quo_t[3:0];
    wire [3:0]  dig_u     = rem_t[3:0];

    // ----------------------------------------------------------------
    // fixed-point arithmetic
    // ----------------------------------------------------------------
    // signed 16-bit arithmetic with overflow
    // results wrap modulo 2^16; only the overflow flag reports the loss
    wire [15:0] sum       = acc2 + acc1;
    wire [15:0] diff      = acc2 - acc1;
    wire        ov_add    = (acc2[15] == acc1[15]) && (sum[15] != acc2[15]);
    wire        ov_sub    = (acc2[15] != acc1[15]) && (diff[15] != acc2[15]);
    wire signed [15:0] s1 = acc1;
    wire signed [15:0] s2 = acc2;

    // ----------------------------------------------------------------
    // next-value logic
    // ----------------------------------------------------------------
    reg         lrb_nxt;
    reg  [15:0] a1_nxt;
    reg  [15:0] a2_nxt;
    reg  [2:0]  cc_nxt;
    reg  [9:0]  cnt_nxt;
    reg         cnt_we;
    reg         cmp;

    // one decoder for all operations; unknown codes change nothing
    always @*
    begin
        lrb_nxt = logic_result_bit_o;
        a1_nxt  = acc1;
        a2_nxt  = acc2;
        cc_nxt  = cond_code_o;
        cnt_nxt = cur_cnt;
        cnt_we  = 1'b0;
        cmp     = 1'b0;
        case (op_code_i)
            `PCAU_OP_SET:
            begin
                if (rise)
                begin
                    cnt_nxt = set_val;
                    cnt_we  = 1'b1;
                end
            end
            `PCAU_OP_RST:
            begin
                // held at zero while bit is one
                if (logic_result_bit_i)
                begin
                    cnt_nxt = 10'h000;
                    cnt_we  = 1'b1;
                end
            end
            `PCAU_OP_UP:
            begin
                // step up on edge; saturate at top
                if (rise && cur_cnt != `PCAU_CNT_MAX)
                begin
                    cnt_nxt = cur_cnt + 10'h001;
                    cnt_we  = 1'b1;
                end
            end
            `PCAU_OP_DOWN:
            begin
                // step down on edge; low bit idles
                if (rise && cur_cnt != 10'h000)
                begin
                    cnt_nxt = cur_cnt - 10'h001;
                    cnt_we  = 1'b1;
                end
            end
            `PCAU_OP_SCAN:
                lrb_nxt = (cur_cnt != 10'h000);
            `PCAU_OP_LDBIN:
            begin
                a2_nxt = acc1;
                a1_nxt = {6'h00, cur_cnt};
            end
            `PCAU_OP_LDBCD:
            begin
                a2_nxt = acc1;
                a1_nxt = {4'h0, dig_h, dig_t, dig_u};
            end
            `PCAU_OP_LDWORD:
            begin
                // plain word load shifts primary down
                a2_nxt = acc1;
                a1_nxt = load_word_i;
            end
            `PCAU_OP_EQ:
            begin
                cmp = (acc2 == acc1);
            end
            `PCAU_OP_NE:
            begin
                cmp = (acc2 != acc1);
            end
            `PCAU_OP_GT:
            begin
                cmp = (s2 > s1);
            end
            `PCAU_OP_GE:
            begin
                cmp = (s2 >= s1);
            end
            `PCAU_OP_LT:
            begin
                cmp = (s2 < s1);
            end
            `PCAU_OP_LE:
            begin
                cmp = (s2 <= s1);
            end
            `PCAU_OP_ADD:
            begin
                a1_nxt = sum;
                // sum to primary and flags set, logic result bit kept
                cc_nxt = {sum[15], (sum != 16'h0000) & ~sum[15], ov_add};
            end
            `PCAU_OP_SUB:
            begin
                a1_nxt = diff;
                cc_nxt = {diff[15], (diff != 16'h0000) & ~diff[15], ov_sub};
            end
            default:
                lrb_nxt = logic_result_bit_o;
        endcase
        if (op_code_i >= `PCAU_OP_EQ && op_code_i <= `PCAU_OP_LE)
        begin
            // verdict to logic result bit; accus untouched
            lrb_nxt = cmp;
            // cc1/cc0 encode less, greater; equal gives 00
            cc_nxt  = {(s2 < s1), (s2 > s1), 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // accumulators may also be written directly by the sequencer when idle
    // an operation wins over accu_wr_i in the same cycle, so no result is torn
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            logic_result_bit_o           <= 1'b0;
            primary_operand_register_o   <= 16'h0000;
            secondary_operand_register_o <= 16'h0000;
            cond_code_o                  <= `PCAU_CC_RST;
            done_o                       <= 1'b0;
        end
        else
        begin
            done_o <= op_valid_i;
            if (op_valid_i)
            begin
                logic_result_bit_o           <= lrb_nxt;
                primary_operand_register_o   <= a1_nxt;
                secondary_operand_register_o <= a2_nxt;
                cond_code_o                  <= cc_nxt;
            end
            else if (accu_wr_i)
            begin
                primary_operand_register_o   <= primary_operand_register_i;
                secondary_operand_register_o <= secondary_operand_register_i;
            end
        end
    end

    // one-hot counter select keeps the per-entry compare free of width casts
    wire [15:0] sel_hot = 16'h0001 << cnt_sel_i;

    // per-counter value and edge memory; edge memory tracks only counter ops
    // the edge memory is shared by set, reset, up and down of one counter
    genvar g;
    generate
        for (g = 0; g < `PCAU_CNT_NUM; g = g + 1)
        begin : g_cnt
            wire sel = op_valid_i && sel_hot[g];
            wire cop = (op_code_i >= `PCAU_OP_SET) && (op_code_i <= `PCAU_OP_DOWN);
            always @(posedge core_clk_i)
            begin
                if (!nrst_i)
                begin
                    count_r[g]    <= 10'h000;
                    edge_mem_r[g] <= 1'b0;
                end
                else if (sel)
                begin
                    if (cnt_we)
                        count_r[g] <= cnt_nxt;
                    if (cop)
                        edge_mem_r[g] <= logic_result_bit_i;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ### dv/pcau_seq_model.sv
/* sequencer model: issues one operation or accumulator write per call.
   assumes the caller runs on the bench clock; drives at falling edges. */
`timescale 1ns/10ps
`default_nettype none
module pcau_seq_model
(
    input  wire logic  clk_i,
    output logic       op_valid_o,
    output logic [4:0] op_code_o,
    output logic [3:0] cnt_sel_o,
    output logic       lrb_o,
    output logic [15:0] prim_o,
    output logic [15:0] sec_o,
    output logic       accu_wr_o
);
    // idle from time zero so no core input floats
    initial {op_valid_o, op_code_o, cnt_sel_o, lrb_o, prim_o, sec_o, accu_wr_o} = '0;
    task issue(input logic [4:0] op, input logic [3:0] sel, input logic lrb);
        @(negedge clk_i);
        {op_valid_o, op_code_o, cnt_sel_o, lrb_o} = {1'b1, op, sel, lrb};
        @(negedge clk_i);
        op_valid_o = 1'b0;
    endtask
    task wr(input logic [15:0] a, input logic [15:0] b);
        @(negedge clk_i);
        {accu_wr_o, prim_o, sec_o} = {1'b1, a, b};
        @(negedge clk_i);
        accu_wr_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### dv/pcau_core_properties.sv
/* checker for the counter, compare and arithmetic unit.
   assumes it is bound to pcau_core and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
`include "pcau_map.vh"
module pcau_core_properties
(
    input wire        core_clk_i,
    input wire        nrst_i,
    input wire        op_valid_i,
    input wire [4:0]  op_code_i,
    input wire [3:0]  cnt_sel_i,
    input wire        logic_result_bit_i,
    input wire [15:0] load_word_i,
    input wire [15:0] primary_operand_register_i,
    input wire [15:0] secondary_operand_register_i,
    input wire        accu_wr_i,
    input wire        logic_result_bit_o,
    input wire [15:0] primary_operand_register_o,
    input wire [15:0] secondary_operand_register_o,
    input wire [2:0]  cond_code_o,
    input wire        done_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // short names; 1f marks no operation this cycle
    wire [4:0]  oc = op_valid_i ? op_code_i : 5'h1f;
    wire [15:0] p = primary_operand_register_o;
    wire [15:0] s = secondary_operand_register_o;
    wire        cmp = oc >= `PCAU_OP_EQ && oc <= `PCAU_OP_LE;
    wire        ar = oc == `PCAU_OP_ADD || oc == `PCAU_OP_SUB;
    cmp_done_a: assert property (cmp |=> done_o) else $error("compare not done");
    eq_verdict_a: assert property (oc == `PCAU_OP_EQ |=> logic_result_bit_o == ($past(p) == $past(s)))
        else $error("eq verdict");
    ne_verdict_a: assert property (oc == `PCAU_OP_NE |=> logic_result_bit_o == ($past(p) != $past(s)))
        else $error("ne verdict");
    gt_verdict_a: assert property (oc == `PCAU_OP_GT
        |=> logic_result_bit_o == ($signed($past(s)) > $signed($past(p)))) else $error("gt");
    le_verdict_a: assert property (oc == `PCAU_OP_LE
        |=> logic_result_bit_o == ($signed($past(s)) <= $signed($past(p)))) else $error("le");
    cmp_keep_a: assert property (cmp |=> $stable(p) && $stable(s)) else $error("accu changed");
    cmp_flags_a: assert property (cmp |=> cond_code_o == {$signed($past(s)) < $signed($past(p)),
        $signed($past(s)) > $signed($past(p)), 1'b0}) else $error("compare flags");
    add_sum_a: assert property (oc == `PCAU_OP_ADD |=> p == 16'($past(s) + $past(p)))
        else $error("add result");
    sub_diff_a: assert property (oc == `PCAU_OP_SUB |=> p == 16'($past(s) - $past(p)))
        else $error("sub result");
    arith_keep_a: assert property (ar |=> $stable(s) && $stable(logic_result_bit_o))
        else $error("arith side effect");
    load_shift_a: assert property (oc == `PCAU_OP_LDBIN |=> s == $past(p) && p <= 16'h03e7)
        else $error("load shift");
    word_load_a: assert property (oc == `PCAU_OP_LDWORD |=> p == $past(load_word_i) && s == $past(p))
        else $error("word load shift");
    cover property (oc == `PCAU_OP_SET && logic_result_bit_i);
    cover property (oc == `PCAU_OP_SUB);
    cover property (oc == `PCAU_OP_GE ##1 logic_result_bit_o);
endmodule
bind pcau_core pcau_core_properties u_pcau_core_properties (
    .core_clk_i                   (core_clk_i),
    .nrst_i                       (nrst_i),
    .op_valid_i                   (op_valid_i),
    .op_code_i                    (op_code_i),
    .cnt_sel_i                    (cnt_sel_i),
    .logic_result_bit_i           (logic_result_bit_i),
    .load_word_i                  (load_word_i),
    .primary_operand_register_i   (primary_operand_register_i),
    .secondary_operand_register_i (secondary_operand_register_i),
    .accu_wr_i                    (accu_wr_i),
    .logic_result_bit_o           (logic_result_bit_o),
    .primary_operand_register_o   (primary_operand_register_o),
    .secondary_operand_register_o (secondary_operand_register_o),
    .cond_code_o                  (cond_code_o),
    .done_o                       (done_o)
);
`default_nettype wire

// ### dv/testbench.sv
/* self-checking bench for pcau_core, random operands from a fixed lfsr.
   assumes the core, its checker and the sequencer model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "pcau_map.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic        clk, nrst, opv, lrbi, aw, lrb, done;
    logic [4:0]  op, o;
    logic [3:0]  sel, c;
    logic [15:0] pi, si, po, so, a, b;
    logic [2:0]  cc;
    logic [19:0] e;
    logic [31:0] rnd = 32'h6fbd6340;
    int          err_count = 0;
    int          n_tests = 0;
    int          n;
    pcau_seq_model u_pcau_seq_model (.clk_i(clk), .op_valid_o(opv), .op_code_o(op),
        .cnt_sel_o(sel), .lrb_o(lrbi), .prim_o(pi), .sec_o(si), .accu_wr_o(aw));
    pcau_core u_pcau_core (.core_clk_i(clk), .nrst_i(nrst), .op_valid_i(opv), .op_code_i(op),
        .cnt_sel_i(sel), .logic_result_bit_i(lrbi), .load_word_i(rnd[15:0]),
        .primary_operand_register_i(pi), .secondary_operand_register_i(si), .accu_wr_i(aw),
        .logic_result_bit_o(lrb), .primary_operand_register_o(po),
        .secondary_operand_register_o(so), .cond_code_o(cc), .done_o(done));
    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function logic [15:0] bcd(input int v);
        return {4'h0, 4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    // expected {verdict, flags, primary}; l is the verdict kept by arithmetic
    function logic [19:0] model(input logic [4:0] k, input logic [15:0] p, s, input logic l);
        logic lt, gt;
        logic [15:0] r;
        lt = $signed(s) < $signed(p);
        gt = $signed(s) > $signed(p);
        r = (k == `PCAU_OP_SUB) ? s - p : s + p;
        case (k)
            `PCAU_OP_EQ: return {s == p, lt, gt, 1'b0, p};
            `PCAU_OP_NE: return {s != p, lt, gt, 1'b0, p};
            `PCAU_OP_GT: return {gt, lt, gt, 1'b0, p};
            `PCAU_OP_GE: return {!lt, lt, gt, 1'b0, p};
            `PCAU_OP_LT: return {lt, lt, gt, 1'b0, p};
            `PCAU_OP_LE: return {!gt, lt, gt, 1'b0, p};
            default: return {l, r[15], !r[15] && r != 0,
                ((k == `PCAU_OP_SUB) ^ (p[15] == s[15])) && r[15] != s[15], r};
        endcase
    endfunction
    task run(input logic [4:0] k, input logic [3:0] q, input logic l);
        u_pcau_seq_model.issue(k, q, l);
    endtask
    task chk_cnt(input int v);
        run(`PCAU_OP_LDBIN, c, 1'b0);
        `CHK(po, 16'(v))
    endtask
    task finish_test;
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // watchdog: several times the expected run
    initial
    begin
        #100000;
        err_count++;
        finish_test;
    end
    initial
    begin
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        `CHK({lrb, po, so, cc, done}, 37'h0)
        rnd = lfsr(rnd);
        c = rnd[3:0];
        n = 1 + rnd[25:16] % 998;
        u_pcau_seq_model.wr(16'h0999, 16'h0);
        run(`PCAU_OP_SET, c, 1'b1);
        chk_cnt(999);
        run(`PCAU_OP_UP, c, 1'b0);
        run(`PCAU_OP_UP, c, 1'b1);
        chk_cnt(999);
        run(`PCAU_OP_RST, c, 1'b1);
        run(`PCAU_OP_SCAN, c, 1'b0);
        `CHK(lrb, 1'b0)
        chk_cnt(0);
        run(`PCAU_OP_DOWN, c, 1'b0);
        run(`PCAU_OP_DOWN, c, 1'b1);
        chk_cnt(0);
        u_pcau_seq_model.wr(bcd(n), 16'h0);
        run(`PCAU_OP_SET, c, 1'b0);
        run(`PCAU_OP_SET, c, 1'b1);
        u_pcau_seq_model.wr(bcd(999 - n), 16'h0);
        run(`PCAU_OP_SET, c, 1'b1);
        chk_cnt(n);
        run(`PCAU_OP_UP, c, 1'b0);
        chk_cnt(n);
        run(`PCAU_OP_UP, c, 1'b1);
        run(`PCAU_OP_UP, c, 1'b1);
        chk_cnt(n + 1);
        run(`PCAU_OP_DOWN, c, 1'b0);
        run(`PCAU_OP_DOWN, c, 1'b1);
        chk_cnt(n);
        run(`PCAU_OP_LDBCD, c, 1'b0);
        `CHK(po, bcd(n))
        run(`PCAU_OP_LDWORD, c, 1'b0);
        `CHK({po, so}, {rnd[15:0], bcd(n)})
        run(`PCAU_OP_SCAN, c, 1'b0);
        `CHK(lrb, 1'b1)
        // an undecoded code keeps every result, though done still pulses
        run(5'h1f, c, 1'b1);
        `CHK({lrb, po, so, done}, {1'b1, rnd[15:0], bcd(n), 1'b1})
        chk_cnt(n);
        // every compare and arithmetic code; last round at the sign boundary
        for (int i = 0; i < 48; i++)
        begin
            rnd = lfsr(rnd);
            a = (i >= 40) ? 16'h7fff : rnd[15:0];
            b = (i >= 40) ? 16'h8000 : ((i % 5 == 4) ? a : rnd[31:16]);
            o = 5'h08 + 5'(i % 8);
            e = model(o, a, b, e[19]);
            u_pcau_seq_model.wr(a, b);
            run(o, rnd[3:0], rnd[4]);
            `CHK({lrb, cc, po, so}, {e, b})
            `CHK(done, 1'b1)
        end
        finish_test;
    end
endmodule
`default_nettype wire
